// ### design/ldfc_top.sv
// Emitter drive and single fault control, reached over APB.
// Assumes a 25 MHz pclk, an asynchronous fault comparator level and an
// external switch transistor gated by source_switch_off_n.
`include "ldfc_map.svh"

module ldfc_top #(
    parameter int unsigned TEST_INTERVAL_CYC = `LDFC_TEST_INTERVAL_CYC,
    parameter int unsigned TEST_SETTLE_CYC = `LDFC_TEST_SETTLE_CYC,
    parameter int unsigned PULSE_PERIOD_CYC = `LDFC_PULSE_PERIOD_CYC,
    parameter int unsigned PULSE_WIDTH_CYC = `LDFC_PULSE_WIDTH_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire ldfc_pkg::ldfc_addr_t paddr,
    input wire ldfc_pkg::ldfc_word_t pwdata,
    output ldfc_pkg::ldfc_word_t prdata,
    output logic pready,
    output logic pslverr,
    // Fault comparator
    input wire logic leak_detect_in,
    // Emitter drive
    output logic drive_enable,
    output logic source_switch_off_n,
    output logic test_path_en,
    // Interrupt
    output logic irq
);
    import ldfc_pkg::*;

    localparam int unsigned PCW = $clog2(PULSE_PERIOD_CYC);

    // ****************************************
    // Declarations
    // ****************************************
    logic leak_meta_r;
    logic leak_sync_r;
    logic [`LDFC_CTRL_WIDTH-1:0] ctrl_r;
    logic [`LDFC_EVT_WIDTH-1:0] status_r;
    logic [`LDFC_EVT_WIDTH-1:0] status_nxt;
    logic [`LDFC_EVT_WIDTH-1:0] int_en_r;
    logic fault_r;
    logic fault_nxt;
    logic [7:0] test_cnt_r;
    logic [PCW-1:0] pulse_cnt_r;
    logic [PCW-1:0] pulse_cnt_nxt;
    ldfc_word_t prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic drive_r;
    logic switch_off_n_r;
    logic path_r;
    logic irq_r;
    logic test_active;
    logic path_en;
    logic test_pass_p;
    logic test_fail_p;

    // ****************************************
    // Comparator synchroniser
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            leak_meta_r <= 1'b0;
            leak_sync_r <= 1'b0;
        end else begin
            leak_meta_r <= leak_detect_in;
            leak_sync_r <= leak_meta_r;
        end
    end

    // ****************************************
    // Self-test sequencer
    // ****************************************
    ldfc_selftest #(
        .INTERVAL_CYC(TEST_INTERVAL_CYC),
        .SETTLE_CYC(TEST_SETTLE_CYC)
    ) u_selftest (
        .clk(pclk),
        .rst_n(presetn),
        .leak_sync(leak_sync_r),
        .test_active_r(test_active),
        .path_en_r(path_en),
        .pass_p_r(test_pass_p),
        .fail_p_r(test_fail_p)
    );

    // ****************************************
    // APB decode
    // ****************************************
    wire setup_ph = psel && !penable;
    wire access_ph = psel && penable && pready_r;
    wire wr_fire = access_ph && pwrite;
    wire sel_ctrl = (paddr == `LDFC_ADDR_CTRL);
    wire sel_status = (paddr == `LDFC_ADDR_STATUS);
    wire sel_int_clr = (paddr == `LDFC_ADDR_INT_CLR);
    wire sel_int_en = (paddr == `LDFC_ADDR_INT_EN);
    wire sel_state = (paddr == `LDFC_ADDR_STATE);
    wire sel_rearm = (paddr == `LDFC_ADDR_REARM);
    wire sel_test_cnt = (paddr == `LDFC_ADDR_TEST_CNT);
    wire addr_hit = sel_ctrl || sel_status || sel_int_clr || sel_int_en ||
        sel_state || sel_rearm || sel_test_cnt;
    wire wr_ctrl = wr_fire && sel_ctrl;
    wire wr_int_clr = wr_fire && sel_int_clr;
    wire wr_int_en = wr_fire && sel_int_en;
    wire wr_rearm = wr_fire && sel_rearm && pwdata[`LDFC_REARM_BIT];

    // ****************************************
    // Read data selection
    // ****************************************
    wire [31:0] rd_state = {29'h0, test_active, fault_r, drive_r};
    wire [31:0] rd_mux =
        sel_ctrl ? {24'h0, ctrl_r} :
        sel_status ? {29'h0, status_r} :
        sel_int_en ? {29'h0, int_en_r} :
        sel_state ? rd_state :
        sel_test_cnt ? {24'h0, test_cnt_r} :
        32'h0;

    // ****************************************
    // Drive control decode
    // ****************************************
    wire hold_off = ctrl_r[`LDFC_CTRL_HOLD_BIT];
    wire [2:0] mode_field = ctrl_r[`LDFC_CTRL_MODE_MSB:`LDFC_CTRL_MODE_LSB];
    wire mode_cw = (mode_field == LDFC_MODE_CW); // RQ3
    wire pulse_on = (pulse_cnt_r < PCW'(PULSE_WIDTH_CYC)); // RQ1
    wire pulse_wrap = (pulse_cnt_r == PCW'(PULSE_PERIOD_CYC - 1));
    wire leak_trip = leak_sync_r && !test_active; // RQ7
    wire drive_nxt = !hold_off && !fault_r && !test_active && // RQ10
        (mode_cw || pulse_on); // RQ2
    wire [`LDFC_EVT_WIDTH-1:0] evt_set = {test_pass_p, test_fail_p, leak_trip};

    always_comb begin
        pulse_cnt_nxt = pulse_wrap ? '0 : pulse_cnt_r + PCW'(1);
        fault_nxt = fault_r;
        if (wr_rearm) begin
            fault_nxt = 1'b0;
        end
        if (leak_trip || test_fail_p) begin
            fault_nxt = 1'b1; // RQ9
        end
        status_nxt = status_r;
        if (wr_int_clr) begin
            status_nxt = status_r & ~pwdata[`LDFC_EVT_WIDTH-1:0];
        end
        status_nxt = status_nxt | evt_set;
    end

    // ****************************************
    // Software registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `LDFC_CTRL_RESET; // RQ4
            int_en_r <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= pwdata[`LDFC_CTRL_WIDTH-1:0];
            end
            if (wr_int_en) begin
                int_en_r <= pwdata[`LDFC_EVT_WIDTH-1:0];
            end
        end
    end

    // ****************************************
    // Fault latch, events and counters
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_r <= 1'b0;
            status_r <= '0;
            test_cnt_r <= 8'h0;
            pulse_cnt_r <= '0;
        end else begin
            fault_r <= fault_nxt;
            status_r <= status_nxt;
            pulse_cnt_r <= pulse_cnt_nxt;
            if (test_pass_p || test_fail_p) begin
                test_cnt_r <= test_cnt_r + 8'h1;
            end
        end
    end

    // ****************************************
    // APB answer
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setup_ph;
            pslverr_r <= setup_ph && !addr_hit;
            prdata_r <= (setup_ph && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // ****************************************
    // Pin and interrupt outputs
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_r <= 1'b0;
            switch_off_n_r <= 1'b1;
            path_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            drive_r <= drive_nxt;
            switch_off_n_r <= fault_r || test_active; // RQ6
            path_r <= path_en; // RQ8
            irq_r <= |(status_r & int_en_r);
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign drive_enable = drive_r;
    assign source_switch_off_n = switch_off_n_r;
    assign test_path_en = path_r;
    assign irq = irq_r;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence leak_seen_s;
        leak_sync_r && !test_active;
    endsequence

    sequence drive_cut_s;
        source_switch_off_n && !drive_enable;
    endsequence

    pulsed_drive_a: assert property (
        drive_enable && !$past(mode_cw) |-> $past(pulse_on)) // RQ1
        else $error("pulsed mode drove outside the pulse window");
    cw_drive_a: assert property (
        $past(mode_cw && !hold_off && !fault_r && !test_active) |-> drive_enable) // RQ2
        else $error("continuous mode did not drive the emitter");
    cw_select_a: assert property (
        wr_ctrl && pwdata[3:1] == 3'h2 |=> mode_cw) // RQ3
        else $error("mode pattern did not select continuous drive");
    hold_release_a: assert property (
        $fell(hold_off) |-> $past(wr_ctrl) && !$past(pwdata[0])) // RQ4
        else $error("hold-off cleared without a software write");
    hold_gate_a: assert property ($past(hold_off) |-> !drive_enable) // RQ10
        else $error("emitter driven while hold-off is set");
    switch_low_a: assert property (
        $past(presetn) && !$past(fault_r) && !$past(test_active) |->
        !source_switch_off_n) // RQ6
        else $error("switch control high with no fault");
    leak_trip_a: assert property (leak_seen_s |=> fault_r ##1 drive_cut_s) // RQ7
        else $error("leak did not cut the emitter drive");
    test_fault_a: assert property (
        test_fail_p |=> fault_r && status_r[`LDFC_EVT_FAIL_BIT]) // RQ9
        else $error("failed self-test not reported");
    test_switch_a: assert property (test_active |=> drive_cut_s) // RQ8
        else $error("self-test ran with the emitter switched on");
    leak_status_a: assert property (leak_seen_s |=> status_r[`LDFC_EVT_LEAK_BIT]) // RQ7
        else $error("leak event not recorded in status");
    fault_drive_a: assert property ($past(fault_r) |-> !drive_enable) // RQ7
        else $error("emitter driven while a fault is latched");
    test_pass_a: assert property (test_pass_p |=> status_r[`LDFC_EVT_PASS_BIT]) // RQ8
        else $error("passed self-test not recorded in status");
    irq_level_a: assert property (|(status_r & int_en_r) |=> irq)
        else $error("enabled event did not raise the interrupt");

endmodule : ldfc_top

// ### design/ldfc_map.svh
// Register map, field positions, reset values and timing counts of the
// emitter drive and fault control block.
// Assumes a 25 MHz pclk and a 32-bit APB with byte addresses.
//
// Summary of operation
// [RQ1] Normal drive energises the emitter in pulses
// [RQ2] Calibration mode drives the emitter continuously
// [RQ3] Mode field 010b at 0x20 selects continuous
// [RQ4] Hold-off bit set after reset, emitter off
// [RQ5] Microcontroller clears hold-off bit at power-up
// [RQ6] No fault keeps switch control output low (code also drives it high during a self-test)
// [RQ7] Leakage to ground stops drive, switch output high
// [RQ8] Periodic self-test grounds node with switch off
// [RQ9] Failed self-test is reported as a fault
// [RQ10] Hold-off forces drive off in any mode
`ifndef LDFC_MAP_SVH
`define LDFC_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define LDFC_ADDR_CTRL 8'h20
`define LDFC_ADDR_STATUS 8'h24
`define LDFC_ADDR_INT_CLR 8'h28
`define LDFC_ADDR_INT_EN 8'h2c
`define LDFC_ADDR_STATE 8'h30
`define LDFC_ADDR_REARM 8'h34
`define LDFC_ADDR_TEST_CNT 8'h38

// ****************************************
// Fields and reset values
// ****************************************
`define LDFC_CTRL_HOLD_BIT 0
`define LDFC_CTRL_MODE_LSB 1
`define LDFC_CTRL_MODE_MSB 3
`define LDFC_CTRL_WIDTH 8
`define LDFC_CTRL_RESET 8'h01
`define LDFC_MODE_PULSED_VAL 3'h0
`define LDFC_MODE_CW_VAL 3'h2
`define LDFC_EVT_LEAK_BIT 0
`define LDFC_EVT_FAIL_BIT 1
`define LDFC_EVT_PASS_BIT 2
`define LDFC_EVT_WIDTH 3
`define LDFC_REARM_BIT 0

// ****************************************
// Timing
// ****************************************
`define LDFC_CLK_PERIOD_NS 40
`define LDFC_PULSE_PERIOD_NS 85000
`define LDFC_PULSE_WIDTH_NS 4000
`define LDFC_TEST_SETTLE_NS 2000
`define LDFC_TEST_INTERVAL_NS 10000000
`define LDFC_PULSE_PERIOD_CYC (`LDFC_PULSE_PERIOD_NS / `LDFC_CLK_PERIOD_NS)
`define LDFC_PULSE_WIDTH_CYC \
    ((`LDFC_PULSE_WIDTH_NS + `LDFC_CLK_PERIOD_NS - 1) / `LDFC_CLK_PERIOD_NS)
`define LDFC_TEST_SETTLE_CYC \
    ((`LDFC_TEST_SETTLE_NS + `LDFC_CLK_PERIOD_NS - 1) / `LDFC_CLK_PERIOD_NS)
`define LDFC_TEST_INTERVAL_CYC (`LDFC_TEST_INTERVAL_NS / `LDFC_CLK_PERIOD_NS)

`endif

// ### design/ldfc_pkg.sv
// Types shared by the emitter drive and fault control files.
// Assumes ldfc_map.svh is on the include path.
`include "ldfc_map.svh"

package ldfc_pkg;

    typedef logic [7:0] ldfc_addr_t;
    typedef logic [31:0] ldfc_word_t;

    typedef enum logic [2:0] {
        LDFC_MODE_PULSED = `LDFC_MODE_PULSED_VAL,
        LDFC_MODE_CW = `LDFC_MODE_CW_VAL
    } ldfc_mode_e;

    typedef enum logic [1:0] {
        LDFC_ST_IDLE = 2'b00,
        LDFC_ST_PROBE = 2'b01,
        LDFC_ST_RECOVER = 2'b10
    } ldfc_st_e;

endpackage : ldfc_pkg

// ### design/ldfc_selftest.sv
// Periodic self-test sequencer of the emitter fault detector.
// Assumes a synchronised detector level on the same clock as the caller.
`include "ldfc_map.svh"

module ldfc_selftest #(
    parameter int unsigned INTERVAL_CYC = `LDFC_TEST_INTERVAL_CYC,
    parameter int unsigned SETTLE_CYC = `LDFC_TEST_SETTLE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Detector level
    input wire logic leak_sync,
    // Sequencer state and results
    output logic test_active_r,
    output logic path_en_r,
    output logic pass_p_r,
    output logic fail_p_r
);
    import ldfc_pkg::*;

    ldfc_st_e st_r;
    logic [31:0] cnt_r;
    wire interval_done = (cnt_r >= (INTERVAL_CYC - 32'd1));
    wire settle_done = (cnt_r == (SETTLE_CYC - 32'd1));

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= LDFC_ST_IDLE;
            cnt_r <= 32'h0;
            test_active_r <= 1'b0;
            path_en_r <= 1'b0;
            pass_p_r <= 1'b0;
            fail_p_r <= 1'b0;
        end else begin
            pass_p_r <= 1'b0;
            fail_p_r <= 1'b0;
            cnt_r <= cnt_r + 32'h1;
            case (st_r)
                LDFC_ST_IDLE: begin
                    if (interval_done) begin
                        st_r <= LDFC_ST_PROBE; // RQ8
                        cnt_r <= 32'h0;
                        test_active_r <= 1'b1;
                        path_en_r <= 1'b1;
                    end
                end
                LDFC_ST_PROBE: begin
                    if (settle_done) begin
                        pass_p_r <= leak_sync;
                        fail_p_r <= !leak_sync; // RQ9
                        path_en_r <= 1'b0;
                        st_r <= LDFC_ST_RECOVER;
                        cnt_r <= 32'h0;
                    end
                end
                LDFC_ST_RECOVER: begin
                    if (settle_done) begin
                        test_active_r <= 1'b0;
                        st_r <= LDFC_ST_IDLE;
                        cnt_r <= 32'h0;
                    end
                end
                default: begin
                    st_r <= LDFC_ST_IDLE;
                    cnt_r <= 32'h0;
                    test_active_r <= 1'b0;
                    path_en_r <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    probe_switch_off_a: assert property (path_en_r |-> test_active_r) // RQ8
        else $error("ground path enabled outside a self-test");
    fail_cause_a: assert property (fail_p_r |-> $past(path_en_r) && !$past(leak_sync)) // RQ9
        else $error("self-test failure without a missing detector response");
    probe_ends_a: assert property ($fell(path_en_r) |-> test_active_r) // RQ8
        else $error("self-test released switch before recovery");

endmodule : ldfc_selftest

// ### verif/ldfc_node_model.sv
// Far side model: emitter cathode node with its leakage comparator.
// Assumes the bench commands the leak and rail-short faults.
module ldfc_node_model (
    // Probe from the block
    input wire logic test_path_en,
    // Commanded faults
    input wire logic leak_fault,
    input wire logic rail_short,
    // Comparator level
    output logic leak_detect_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // Comparator
    // ****************************************
    // Rail short holds the node up, so the probe path is never seen
    assign leak_detect_in = rail_short ? 1'b0 : (test_path_en | leak_fault);
endmodule : ldfc_node_model

// ### verif/tb_top.sv
// Self-checking bench of the emitter drive and fault control block.
// Assumes ldfc_pkg compiled first and ldfc_map.svh on the include path.
`include "ldfc_map.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ldfc_pkg::*;
    localparam int P = 20;
    localparam int W = 5;
    localparam int S = 4;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    ldfc_addr_t paddr = '0;
    ldfc_word_t pwdata = '0, prdata, r;
    logic leak_detect_in, drive_enable, source_switch_off_n, test_path_en, irq, e;
    logic leak_fault = 0, rail_short = 0;
    int n_errors = 0, tests_run = 0, cyc = 0, c, ctrl_m;
    int exp_q[$];
    int n_probe = 0;
    logic tp_q = 0;

    // ****************************************
    // Design and far side
    // ****************************************
    ldfc_top #(.TEST_INTERVAL_CYC(300), .TEST_SETTLE_CYC(S), .PULSE_PERIOD_CYC(P),
        .PULSE_WIDTH_CYC(W)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .leak_detect_in(leak_detect_in), .drive_enable(drive_enable),
        .source_switch_off_n(source_switch_off_n), .test_path_en(test_path_en), .irq(irq));
    ldfc_node_model u_node (.test_path_en(test_path_en), .leak_fault(leak_fault),
        .rail_short(rail_short), .leak_detect_in(leak_detect_in));

    always #20 pclk = ~pclk;

    // ****************************************
    // Checks and bus tasks
    // ****************************************
    task tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    task cmp_word(input ldfc_word_t got, input ldfc_word_t exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
        end
    endtask : cmp_word

    task cmp_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t pin %b expected %b", $time, got, exp);
        end
    endtask : cmp_bit

    task apb(input logic w, input ldfc_addr_t a, input ldfc_word_t d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (n == 50) begin
            n_errors++;
            tally_and_finish();
        end
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    task wait_pin(input int which, input logic v, input int max);
        int n;
        n = 0;
        while ((which == 0 ? source_switch_off_n : test_path_en) !== v && n < max) begin
            n++;
            @(posedge pclk);
        end
        cmp_bit(n < max, 1'b1);
    endtask : wait_pin

    task count_drive(input int n);
        c = 0;
        repeat (n) begin
            @(posedge pclk);
            if (drive_enable === 1'b1) c++;
        end
    endtask : count_drive

    // Start measuring just after a self-test has ended
    task after_test;
        wait_pin(1, 1'b1, 400);
        wait_pin(0, 1'b0, 4 * S + 20);
        repeat (3) @(posedge pclk);
    endtask : after_test

    // Probe period must keep the emitter off
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        tp_q <= test_path_en;
        if (presetn && test_path_en === 1'b1 && tp_q !== 1'b1) begin
            n_probe <= n_probe + 1;
        end
        if (cyc == 30000) begin
            n_errors++;
            tally_and_finish();
        end
        if (presetn && test_path_en === 1'b1) begin
            cmp_bit(source_switch_off_n, 1'b1);
            cmp_bit(drive_enable, 1'b0);
        end
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        void'($urandom(75));
        repeat (16) @(posedge pclk);
        presetn <= 1;
        repeat (2) @(posedge pclk);
        apb(0, `LDFC_ADDR_CTRL, 0);
        cmp_word(r, 32'h0000_0001);
        cmp_bit(source_switch_off_n, 1'b0);
        count_drive(3 * P);
        cmp_word(c, 0);
        apb(0, 8'h3c, 0);
        cmp_bit(e, 1'b1);
        cmp_word(r, 0);
        $display("test reset done");
        ctrl_m = $urandom & 32'hfe;
        if (ctrl_m[3:1] == 3'h2) ctrl_m = ctrl_m ^ 32'h2;
        apb(1, `LDFC_ADDR_CTRL, ($urandom & 32'hffff_ff00) | ctrl_m);
        apb(0, `LDFC_ADDR_CTRL, 0);
        cmp_word(r, ctrl_m);
        after_test();
        count_drive(3 * P);
        cmp_word(c, 3 * W);
        apb(0, `LDFC_ADDR_STATUS, 0);
        cmp_word(r & 32'h7, 32'h4);
        $display("test pulsed done");
        exp_q = '{3 * P, 0};
        foreach (exp_q[i]) begin
            apb(1, `LDFC_ADDR_CTRL, (ctrl_m & 32'hf0) | 4 | i);
            after_test();
            count_drive(3 * P);
            cmp_word(c, exp_q[i]);
        end
        $display("test modes done");
        apb(1, `LDFC_ADDR_CTRL, 4);
        apb(1, `LDFC_ADDR_INT_CLR, 7);
        leak_fault <= 1;
        wait_pin(0, 1'b1, 4 * S + 20);
        repeat (12) @(posedge pclk);
        cmp_bit(source_switch_off_n, 1'b1);
        cmp_bit(drive_enable, 1'b0);
        apb(0, `LDFC_ADDR_STATUS, 0);
        cmp_word(r & 32'h1, 32'h1);
        exp_q = '{1, 0};
        foreach (exp_q[i]) begin
            apb(1, `LDFC_ADDR_INT_EN, exp_q[i]);
            repeat (3) @(posedge pclk);
            cmp_bit(irq, exp_q[i][0]);
        end
        leak_fault <= 0;
        apb(1, `LDFC_ADDR_INT_EN, 1);
        apb(1, `LDFC_ADDR_INT_CLR, 1);
        repeat (3) @(posedge pclk);
        cmp_bit(irq, 1'b0);
        apb(1, `LDFC_ADDR_REARM, 1);
        wait_pin(0, 1'b0, 4 * S + 20);
        $display("test leak done");
        rail_short <= 1;
        apb(1, `LDFC_ADDR_INT_CLR, 7);
        wait_pin(1, 1'b1, 400);
        repeat (4 * S + 10) @(posedge pclk);
        cmp_bit(source_switch_off_n, 1'b1);
        apb(0, `LDFC_ADDR_STATUS, 0);
        cmp_word(r & 32'h3, 32'h2);
        apb(0, `LDFC_ADDR_STATE, 0);
        cmp_word(r & 32'h2, 32'h2);
        apb(0, `LDFC_ADDR_TEST_CNT, 0);
        cmp_word(r, n_probe);
        rail_short <= 0;
        apb(1, `LDFC_ADDR_REARM, 1);
        wait_pin(0, 1'b0, 4 * S + 20);
        $display("test selftest fail done");
        tally_and_finish();
    end
endmodule : tb_top
